// ===== core/common_pin_select.sv
// common pin function selection: duty, paralleling and port release
`timescale 1ns/1ns
module common_pin_select (
  input wire lcd_pin_pkg::duty_t duty,
  input wire logic common_multiplex,
  input wire logic all_port,
  input wire logic [3:0] common_wave,
  input wire logic common_nonselect,
  output logic [3:0] com_lcd_val,
  output logic [3:0] com_is_port
);
  import lcd_pin_pkg::*;

  // ----------------------------------------------------------------
  // waveform and port choice per common pin
  // ----------------------------------------------------------------
  always_comb begin
    com_lcd_val = common_wave;
    com_is_port = 4'h0;
    unique case (duty)
      DUTY_STATIC: begin
        if (common_multiplex) begin
          com_lcd_val = {4{common_wave[0]}};
        end else begin
          com_is_port = 4'hE;
        end
      end
      DUTY_HALF: begin
        if (common_multiplex) begin
          com_lcd_val = {common_wave[1], common_wave[1], common_wave[0], common_wave[0]};
        end else begin
          com_is_port = 4'hC;
        end
      end
      DUTY_THIRD: begin
        if (common_multiplex) begin
          com_lcd_val = {common_nonselect, common_wave[2:0]};
        end else begin
          com_is_port = 4'h8;
        end
      end
      DUTY_QUARTER: begin
        com_lcd_val = common_wave;
      end
    endcase
    // no segment in use at all: every common becomes a port
    if (all_port) begin
      com_is_port = 4'hF;
    end
  end

endmodule : common_pin_select

// ===== core/lcd_pin_function_select.sv
// lcd pin control register and segment/common pin function mux
//
// Summary of operation
// - 8-bit control register, all bits read/write
// - reset clears control register to zero
// - two duty bits pick static, half, third, quarter
// - unused commons become ports when multiplex clear
// - static multiplexed: commons 2-4 copy common 1
// - half multiplexed: com4 copies com3, com2 com1
// - third multiplexed: common 4 drives non-select waveform
// - no expansion, group zero: all commons ports
// - expansion bit turns top four pins expansion
// - no expansion, group zero: top pins ports
// - group code enables segment groups from top
// - expansion latch and shift clocks feed driver
`timescale 1ns/1ns
module lcd_pin_function_select #(
  parameter int SEG_COUNT = 40
) (
  input wire logic clock,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [lcd_pin_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // lcd waveform sources
  input wire logic [3:0] common_wave,
  input wire logic common_nonselect,
  input wire logic [SEG_COUNT-1:0] segment_wave,
  input wire logic expansion_latch_clock,
  input wire logic expansion_shift_clock,
  input wire logic expansion_data,
  input wire logic expansion_alternating,
  // general-purpose port logic
  input wire logic [3:0] common_port_data,
  input wire logic [3:0] common_port_oe,
  input wire logic [SEG_COUNT-1:0] segment_port_data,
  input wire logic [SEG_COUNT-1:0] segment_port_oe,
  // pins
  output logic [3:0] common_drive_pin,
  output logic [3:0] common_drive_pin_oe,
  output logic [SEG_COUNT-1:0] segment_drive_pin,
  output logic [SEG_COUNT-1:0] segment_drive_pin_oe
);
  import lcd_pin_pkg::*;

  localparam int GROUPS = SEG_COUNT / PINS_PER_GROUP;

  if (SEG_COUNT != SEG_PINS) begin : g_check
    $error("segment count must equal the decoded pin table");
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0] pin_control_q;
  logic [31:0] readdata_q;
  logic waitrequest_q;
  logic first_q;
  wire req = read || write;
  wire accept = req && !waitrequest_q;
  wire hit_control = (address == PIN_CONTROL_OFFSET);
  wire hit_status = (address == PIN_STATUS_OFFSET);
  wire control_we = accept && write && hit_control && byteenable[0];

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire duty_select_hi = pin_control_q[DUTY_HI_BIT];
  wire duty_select_lo = pin_control_q[DUTY_LO_BIT];
  wire common_multiplex = pin_control_q[COMMON_MUX_BIT];
  wire expansion_select = pin_control_q[EXPANSION_BIT];
  wire [3:0] group_code = pin_control_q[GROUP_SEL_HI:GROUP_SEL_LO];
  wire duty_t duty = duty_t'({duty_select_hi, duty_select_lo});
  wire all_port = !expansion_select && (group_code == 4'h0);

  // ----------------------------------------------------------------
  // pin function decode
  // ----------------------------------------------------------------
  logic [3:0] com_lcd_val;
  logic [3:0] com_is_port;
  logic [GROUPS-1:0] group_is_seg;
  logic top_is_expansion;
  logic [3:0] group_count;

  common_pin_select u_common (
    .duty(duty),
    .common_multiplex(common_multiplex),
    .all_port(all_port),
    .common_wave(common_wave),
    .common_nonselect(common_nonselect),
    .com_lcd_val(com_lcd_val),
    .com_is_port(com_is_port)
  );

  segment_pin_select #(
    .GROUPS(GROUPS)
  ) u_segment (
    .expansion_select(expansion_select),
    .group_code(group_code),
    .group_is_seg(group_is_seg),
    .top_is_expansion(top_is_expansion),
    .group_count(group_count)
  );

  // ----------------------------------------------------------------
  // next pin values, top four pins carry expansion signals
  // ----------------------------------------------------------------
  wire [3:0] expansion_bus = {expansion_latch_clock, expansion_shift_clock,
                              expansion_data, expansion_alternating};
  logic [SEG_COUNT-1:0] seg_lcd_val;
  logic [SEG_COUNT-1:0] seg_is_lcd;
  for (genvar p = 0; p < SEG_COUNT; p++) begin : g_seg
    localparam int G = (SEG_COUNT - 1 - p) / PINS_PER_GROUP;
    if (G == 0) begin : g_top
      assign seg_lcd_val[p] = top_is_expansion ? expansion_bus[p - (SEG_COUNT - 4)]
                                               : segment_wave[p];
      assign seg_is_lcd[p] = top_is_expansion || group_is_seg[G];
    end else begin : g_low
      assign seg_lcd_val[p] = segment_wave[p];
      assign seg_is_lcd[p] = group_is_seg[G];
    end
  end

  // port logic takes every released pin
  wire [SEG_COUNT-1:0] seg_d = (seg_is_lcd & seg_lcd_val) | (~seg_is_lcd & segment_port_data);
  wire [SEG_COUNT-1:0] seg_oe_d = seg_is_lcd | segment_port_oe;
  wire [3:0] com_d = (~com_is_port & com_lcd_val) | (com_is_port & common_port_data);
  wire [3:0] com_oe_d = ~com_is_port | common_port_oe;

  wire [31:0] status_word = {23'h000000, com_is_port, top_is_expansion, group_count};
  wire [31:0] readdata_d = hit_control ? {24'h000000, pin_control_q} :
                           hit_status ? status_word : UNMAPPED_READ;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_control_q <= PIN_CONTROL_RESET;
    end else if (control_we) begin
      pin_control_q <= writedata[7:0];
    end
  end

  // one wait cycle, then the answer stands for a single edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else begin
      waitrequest_q <= !(req && waitrequest_q);
      if (read && waitrequest_q) begin
        readdata_q <= readdata_d;
      end
    end
  end

  // registered pins: every reconfiguration lands on one clock edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      common_drive_pin <= 4'h0;
      common_drive_pin_oe <= 4'h0;
      segment_drive_pin <= '0;
      segment_drive_pin_oe <= '0;
    end else begin
      common_drive_pin <= com_d;
      common_drive_pin_oe <= com_oe_d;
      segment_drive_pin <= seg_d;
      segment_drive_pin_oe <= seg_oe_d;
    end
  end

  // marks the first edge after reset release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  reset_value_a: assert property (
    @(posedge clock) disable iff (!resetn) first_q |-> pin_control_q == PIN_CONTROL_RESET)
    else $error("control register not cleared by reset");

  write_store_a: assert property (
    @(posedge clock) disable iff (!resetn)
    control_we |=> pin_control_q == $past(writedata[7:0]))
    else $error("control write not stored");

  read_back_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (accept && read && hit_control) |-> readdata[7:0] == pin_control_q && readdata[31:8] == 24'h0)
    else $error("control read does not return register");

  bus_answer_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (req && waitrequest_q) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not after one wait cycle");

  static_parallel_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (duty == DUTY_STATIC && common_multiplex && !all_port)
    |=> common_drive_pin == {4{$past(common_wave[0])}} && common_drive_pin_oe == 4'hF)
    else $error("static paralleled commons differ from common 1");

  static_release_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (duty == DUTY_STATIC && !common_multiplex && !all_port)
    |=> common_drive_pin[3:1] == $past(common_port_data[3:1])
        && common_drive_pin[0] == $past(common_wave[0]))
    else $error("static duty commons 2-4 not released");

  half_parallel_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (duty == DUTY_HALF && common_multiplex && !all_port)
    |=> common_drive_pin[3] == common_drive_pin[2] && common_drive_pin[1] == common_drive_pin[0])
    else $error("half duty paralleled commons differ");

  third_nonselect_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (duty == DUTY_THIRD && common_multiplex && !all_port)
    |=> common_drive_pin[3] == $past(common_nonselect))
    else $error("common 4 not non-select at third duty");

  all_port_a: assert property (
    @(posedge clock) disable iff (!resetn)
    all_port |=> common_drive_pin == $past(common_port_data)
                 && segment_drive_pin == $past(segment_port_data))
    else $error("pins not released as ports");

  expansion_pins_a: assert property (
    @(posedge clock) disable iff (!resetn)
    expansion_select |=> segment_drive_pin[SEG_COUNT-1 -: 4] == $past(expansion_bus)
                         && segment_drive_pin_oe[SEG_COUNT-1 -: 4] == 4'hF)
    else $error("expansion signals not on top pins");

  group_one_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (group_code == 4'h1 && !expansion_select)
    |=> segment_drive_pin[SEG_COUNT-1 -: 8] == $past(segment_wave[SEG_COUNT-1 -: 8])
        && segment_drive_pin[SEG_COUNT-9:0] == $past(segment_port_data[SEG_COUNT-9:0]))
    else $error("group code one does not enable top eight pins");

  quarter_drive_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (duty == DUTY_QUARTER && !all_port)
    |=> common_drive_pin == $past(common_wave) && common_drive_pin_oe == 4'hF)
    else $error("quarter duty commons not all driven");

  half_release_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (duty == DUTY_HALF && !common_multiplex && !all_port)
    |=> common_drive_pin[3:2] == $past(common_port_data[3:2])
        && common_drive_pin[1:0] == $past(common_wave[1:0]))
    else $error("half duty commons 3-4 not released");

  third_release_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (duty == DUTY_THIRD && !common_multiplex && !all_port)
    |=> common_drive_pin[3] == $past(common_port_data[3])
        && common_drive_pin[2:0] == $past(common_wave[2:0]))
    else $error("third duty common 4 not released");

  port_enable_a: assert property (
    @(posedge clock) disable iff (!resetn)
    all_port |=> common_drive_pin_oe == $past(common_port_oe)
                 && segment_drive_pin_oe == $past(segment_port_oe))
    else $error("released pins do not take port enables");

  segment_top_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (!expansion_select && group_code != 4'h0)
    |=> segment_drive_pin[SEG_COUNT-1 -: 4] == $past(segment_wave[SEG_COUNT-1 -: 4]))
    else $error("top pins not segment drivers");

  group_six_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (group_code == 4'h6 && !expansion_select)
    |=> segment_drive_pin[SEG_COUNT-1 -: 28] == $past(segment_wave[SEG_COUNT-1 -: 28])
        && segment_drive_pin[SEG_COUNT-29:0] == $past(segment_port_data[SEG_COUNT-29:0]))
    else $error("group code six does not enable top 28 pins");

  group_all_a: assert property (
    @(posedge clock) disable iff (!resetn)
    (group_code[3] && group_code[0] && !expansion_select)
    |=> segment_drive_pin == $past(segment_wave) && segment_drive_pin_oe == '1)
    else $error("all groups not segment drivers");

  idle_wait_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !req |=> waitrequest)
    else $error("waitrequest low without a request");

endmodule : lcd_pin_function_select

// ===== core/lcd_pin_pkg.sv
// constants and types shared by the lcd pin function select block
package lcd_pin_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the avalon slave)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] PIN_CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] PIN_STATUS_OFFSET = 4'h4;
  localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int DUTY_HI_BIT = 7;
  localparam int DUTY_LO_BIT = 6;
  localparam int COMMON_MUX_BIT = 5;
  localparam int EXPANSION_BIT = 4;
  localparam int GROUP_SEL_HI = 3;
  localparam int GROUP_SEL_LO = 0;

  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int STAT_GROUPS_LO = 0;
  localparam int STAT_EXP_BIT = 4;
  localparam int STAT_COM_PORT_LO = 5;

  // ----------------------------------------------------------------
  // pin counts
  // ----------------------------------------------------------------
  localparam int SEG_PINS = 40;
  localparam int PINS_PER_GROUP = 4;
  localparam int COM_PINS = 4;

  typedef enum logic [1:0] {
    DUTY_STATIC,
    DUTY_HALF,
    DUTY_THIRD,
    DUTY_QUARTER
  } duty_t;

endpackage : lcd_pin_pkg

// ===== core/segment_pin_select.sv
// segment group enables and expansion selection
`timescale 1ns/1ns
module segment_pin_select #(
  parameter int GROUPS = 10
) (
  input wire logic expansion_select,
  input wire logic [3:0] group_code,
  output logic [GROUPS-1:0] group_is_seg,
  output logic top_is_expansion,
  output logic [3:0] group_count
);
  import lcd_pin_pkg::*;

  // the code table below only knows ten groups
  if (GROUPS != 10) begin : g_check
    $error("group decode serves exactly ten groups");
  end

  // number of groups enabled from the top for a select code
  function automatic logic [3:0] enabled_groups(input logic [3:0] code);
    logic [3:0] n;
    n = 4'h0;
    if (code[3]) begin
      n = code[0] ? 4'hA : 4'h9;
    end else if (code == 4'h7) begin
      n = 4'h8;
    end else if (code != 4'h0) begin
      n = code + 4'h1;
    end
    return n;
  endfunction : enabled_groups

  // ----------------------------------------------------------------
  // group decode, group 0 is the top group
  // ----------------------------------------------------------------
  assign group_count = enabled_groups(group_code);
  assign top_is_expansion = expansion_select;

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    if (g == 0) begin : g_top
      assign group_is_seg[g] = !expansion_select && (group_count != 4'h0);
    end else begin : g_rest
      assign group_is_seg[g] = (4'(g) < group_count);
    end
  end

endmodule : segment_pin_select

// ===== test/expansion_driver_model.sv
// behavioural model of the external segment expansion driver
`timescale 1ns/1ns
module expansion_driver_model (
  input wire logic [39:0] segment_drive_pin,
  input wire logic [39:0] segment_drive_pin_oe,
  output logic [7:0] latched
);
  logic [7:0] shift_q = 8'h00;
  logic [7:0] latch_q = 8'h00;

  assign latched = latch_q;

  // serial data shifts in on the shift clock, only while the pin carries it
  always @(posedge segment_drive_pin[38]) begin
    if (segment_drive_pin_oe[38] && segment_drive_pin_oe[37]) begin
      shift_q <= {shift_q[6:0], segment_drive_pin[37]};
    end
  end

  // latch clock copies the shifted word to the display outputs
  always @(posedge segment_drive_pin[39]) begin
    if (segment_drive_pin_oe[39]) begin
      latch_q <= shift_q;
    end
  end
endmodule : expansion_driver_model

// ===== test/testbench.sv
// self-checking bench for the lcd pin function select block
`timescale 1ns/1ns
module testbench;
  import lcd_pin_pkg::*;
  logic clock, resetn, read, write, waitrequest, common_nonselect;
  logic expansion_latch_clock, expansion_shift_clock, expansion_data, expansion_alternating;
  logic [3:0] address, byteenable, common_wave, common_port_data, common_port_oe;
  logic [3:0] common_drive_pin, common_drive_pin_oe;
  logic [31:0] writedata, readdata, rd;
  logic [39:0] segment_wave, segment_port_data, segment_port_oe;
  logic [39:0] segment_drive_pin, segment_drive_pin_oe;
  logic [7:0] latched;
  int miscompares, n_checks;
  wire [7:0] com_seen = {common_drive_pin_oe, common_drive_pin};

  lcd_pin_function_select #(.SEG_COUNT(40)) u_dut (.clock, .resetn, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest, .common_wave, .common_nonselect,
    .segment_wave, .expansion_latch_clock, .expansion_shift_clock, .expansion_data,
    .expansion_alternating, .common_port_data, .common_port_oe, .segment_port_data,
    .segment_port_oe, .common_drive_pin, .common_drive_pin_oe, .segment_drive_pin,
    .segment_drive_pin_oe);

  expansion_driver_model u_partner (.segment_drive_pin, .segment_drive_pin_oe, .latched);

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // one avalon transfer, entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    int i;
    address <= a;
    writedata <= wd;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      miscompares++;
      stop_test();
    end else begin
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
    end
  endtask : bus

  function automatic logic [7:0] exp_com(int d, bit m, bit ap);
    logic [3:0] lcd, v;
    lcd = 4'h0;
    v = 4'h0;
    for (int k = 0; k <= d; k++) begin
      lcd[k] = 1'b1;
      v[k] = common_wave[k];
    end
    if (m && d == 0) v = {4{common_wave[0]}};
    if (m && d == 1) v = {common_wave[1], common_wave[1], common_wave[0], common_wave[0]};
    if (m && d == 2) v[3] = common_nonselect;
    if (m) lcd = 4'hF;
    if (ap) lcd = 4'h0;
    return {lcd | common_port_oe, (v & lcd) | (common_port_data & ~lcd)};
  endfunction : exp_com

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic test_reset;
    bus(1'b0, PIN_CONTROL_OFFSET, 32'h0, 4'hF);
    check(rd, 32'h0, "control after reset");
    @(negedge clock);
    check({common_drive_pin_oe, common_drive_pin}, exp_com(0, 0, 1), "commons reset");
    check(segment_drive_pin_oe, segment_port_oe, "segment oe reset");
    check(segment_drive_pin, segment_port_data, "segment value reset");
    @(posedge clock);
  endtask : test_reset

  task automatic test_reg;
    logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    foreach (pat[i]) begin
      bus(1'b1, PIN_CONTROL_OFFSET, {24'hFFFFFF, pat[i]}, 4'hF);
      bus(1'b0, PIN_CONTROL_OFFSET, 32'h0, 4'hF);
      check(rd, {24'h0, pat[i]}, "control readback");
    end
    bus(1'b1, PIN_CONTROL_OFFSET, 32'h3C, 4'hE);
    bus(1'b1, PIN_STATUS_OFFSET, 32'hFF, 4'hF);
    bus(1'b1, 4'h8, 32'h77, 4'hF);
    bus(1'b0, 4'h8, 32'h0, 4'hF);
    check(rd, UNMAPPED_READ, "unmapped read");
    bus(1'b0, PIN_CONTROL_OFFSET, 32'h0, 4'hF);
    check(rd, 32'h0, "control after refused writes");
  endtask : test_reg

  task automatic test_commons;
    logic [7:0] e;
    for (int w = 0; w < 2; w++) begin
      common_wave <= w ? 4'h9 : 4'h6;
      common_port_data <= w ? 4'h6 : 4'h9;
      common_nonselect <= w ? 1'b0 : 1'b1;
      for (int c = 0; c < 16; c++) begin
        bus(1'b1, PIN_CONTROL_OFFSET, {24'h0, c[3:1], c[0], 4'h0}, 4'hF);
        bus(1'b1, PIN_CONTROL_OFFSET, {24'h0, c[3:2], c[1], 1'b0, 3'h0, c[0]}, 4'hF);
        @(negedge clock);
        e = exp_com(c[3:2], c[1], !c[0]);
        check(com_seen, e, "common pins");
        @(posedge clock);
      end
    end
  endtask : test_commons

  task automatic test_segments;
    logic [39:0] mask, top, val;
    int n;
    for (int x = 0; x < 2; x++) begin
      for (int code = 0; code < 16; code++) begin
        bus(1'b1, PIN_CONTROL_OFFSET, {24'h0, 3'b110, x[0], code[3:0]}, 4'hF);
        // groups enabled from the top: codes 7 and above give 8, 9 or 10
        n = (code == 0) ? 0 : (code < 7) ? code + 1 : (code == 7) ? 8 : 9 + code % 2;
        mask = (n == 0) ? 40'h0 : ~(40'hFF_FFFF_FFFF >> (4 * n));
        top = x ? 40'hF0_0000_0000 : 40'h0;
        val = (segment_wave & mask & ~top) | (segment_port_data & ~(mask | top)) |
              (x ? {expansion_latch_clock, expansion_shift_clock, expansion_data,
                    expansion_alternating, 36'h0} : 40'h0);
        @(negedge clock);
        check(segment_drive_pin_oe, mask | top | segment_port_oe, "segment oe");
        check(segment_drive_pin, val, "segment values");
        check(com_seen, exp_com(3, 0, !x && code == 0), "commons with expansion");
        @(posedge clock);
        bus(1'b0, PIN_STATUS_OFFSET, 32'h0, 4'hF);
        check(rd, {23'h0, {4{!x[0] && code == 0}}, x[0], 4'(n)}, "status word");
      end
    end
  endtask : test_segments

  task automatic test_expansion;
    logic [7:0] word = 8'hC5;
    bus(1'b1, PIN_CONTROL_OFFSET, 32'h11, 4'hF);
    for (int i = 7; i >= 0; i--) begin
      expansion_data <= word[i];
      @(posedge clock);
      expansion_shift_clock <= 1'b1;
      @(posedge clock);
      expansion_shift_clock <= 1'b0;
      @(posedge clock);
    end
    expansion_latch_clock <= 1'b1;
    @(posedge clock);
    expansion_latch_clock <= 1'b0;
    repeat (3) @(posedge clock);
    check(latched, word, "expansion word latched");
  endtask : test_expansion

  // reset in mid-run must clear a non-zero control value and the pins
  task automatic test_mid_reset;
    resetn <= 1'b0;
    @(negedge clock);
    check(com_seen, 8'h00, "commons in reset");
    check(segment_drive_pin_oe, 40'h0, "segment oe in reset");
    check(segment_drive_pin, 40'h0, "segments in reset");
    check({waitrequest, readdata}, 33'h1_0000_0000, "bus in reset");
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    test_reset();
  endtask : test_mid_reset

  // --------------------------------------------------------------
  // clock, reset and main sequence
  // --------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    resetn = 1'b0; read = 1'b0; write = 1'b0; address = 4'h0; byteenable = 4'h0;
    writedata = 32'h0; common_wave = 4'h6; common_nonselect = 1'b1;
    common_port_data = 4'h9; common_port_oe = 4'h5;
    segment_wave = 40'hA5_5A3C_C3F0; segment_port_data = 40'h5A_A5C3_3C0F;
    segment_port_oe = 40'h0F_F00F_F00F; expansion_latch_clock = 1'b0;
    expansion_shift_clock = 1'b0; expansion_data = 1'b0; expansion_alternating = 1'b1;
    miscompares = 0; n_checks = 0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    test_reset();
    test_reg();
    test_commons();
    test_segments();
    test_expansion();
    test_mid_reset();
    stop_test();
  end
endmodule : testbench
